//--- verification/waveform_output_timing_tb_top.sv
`include "wot_regs.svh"
module waveform_output_timing_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, prdy, perr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] pfi_in, pfi_out, pfi_oe_n;
  logic [7:0]  rt_in, rt_out, rt_oe_n;
  logic [4:0]  misc;
  logic        cmp, gp, tb100, beg, upd, pop;
  logic        run, begin_lvl, hold_lvl, ext_lvl, cmp_lvl, tb_q;
  int          n_errors, checked, n_tick, n_beg, n_all, n_pop;
  int          upd_q[$];
  logic [1:0]  rt_mode;
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  wot_timing dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(prdy), .pslverr(perr),
    .programmable_function_terminals_in(pfi_in), .interboard_trigger_lines_in(rt_in),
    .backplane_star_trigger(misc[0]), .backplane_10mhz_clock(misc[1]),
    .input_reference_trigger(misc[2]), .input_begin_trigger(misc[3]),
    .comparison_event(cmp), .gp_counter_out(gp), .timebase_20mhz(misc[4]),
    .timebase_100khz(tb100), .programmable_function_terminals_out(pfi_out),
    .programmable_function_terminals_oe_n(pfi_oe_n), .interboard_trigger_lines_out(rt_out),
    .interboard_trigger_lines_oe_n(rt_oe_n), .output_begin_trigger(beg),
    .dac_update(upd), .fifo_pop(pop)
  );
  wot_src_model src (
    .pclk(pclk), .presetn(presetn), .run(run), .begin_lvl(begin_lvl),
    .hold_lvl(hold_lvl), .ext_lvl(ext_lvl), .cmp_lvl(cmp_lvl), .fifo_pop(pop),
    .pfi(pfi_in), .rtsi(rt_in), .misc(misc), .cmp(cmp), .gp(gp), .tb100(tb100),
    .n_pop(n_pop)
  );
  // ****************************************************************
  // checking and bus tasks
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask
  function automatic int exp_tick(input int d, input int v, input int k);
    return d + v * k;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (prdy !== 1'b1 && k < 40);
    if (k >= 40) n_errors++;
    q = prdata;
    e = perr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // interboard line 0 shows begin (0), update clock (1) or hold (2)
  task automatic rt_sel(input logic [1:0] m);
    apb(1'b1, `WOT_OFS_EXPORT, {5'h0, m, 25'h0030020});
    rt_mode <= m;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, x, q);
  endtask
  // waits a bounded time for the begin pulse
  task automatic start_wait;
    int k;
    k = n_beg;
    repeat (12) if (n_beg == k) @(posedge pclk);
    chk("begin_pulse", k + 1, n_beg);
  endtask
  task automatic pulse;
    ext_lvl <= ~ext_lvl;
    cyc(6);
    ext_lvl <= ~ext_lvl;
    cyc(6);
  endtask
  task automatic end_of_test;
    chk("fifo_pops", n_all, n_pop);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic gen(input logic [4:0] s, input logic f, input int d, input int v, input int c);
    logic l;
    l = (s == `WOT_SRC_CMP) ? 1'b0 : f;
    apb(1'b1, `WOT_OFS_BEGIN, {25'h0, 1'b1, f, s});
    apb(1'b1, `WOT_OFS_CLOCK, 32'h1E00);
    apb(1'b1, `WOT_OFS_DELAY, d);
    apb(1'b1, `WOT_OFS_DIVISOR, v);
    apb(1'b1, `WOT_OFS_COUNT, c);
    begin_lvl <= l;
    cmp_lvl <= l;
    apb(1'b1, `WOT_OFS_CTRL, 32'h19);
    upd_q.delete();
    run <= 1'b1;
    cyc(40);
    run <= 1'b0;
    chk("armed_updates", 0, upd_q.size());
    rd(`WOT_OFS_STATUS, 32'h1, "armed_state");
    begin_lvl <= ~l;
    cmp_lvl <= ~l;
    start_wait;
    n_tick = 0;
    run <= 1'b1;
    cyc(8 * (d + v * c + 3));
    run <= 1'b0;
    chk("n_updates", c, upd_q.size());
    chk("first_tick", exp_tick(d, v, 0), upd_q[0]);
    for (int k = 1; k < upd_q.size(); k++) chk("period", v, upd_q[k] - upd_q[k-1]);
    apb(1'b0, `WOT_OFS_STATUS, 32'h0);
    chk("auto_stop", 0, q & 32'h3);
    rd(`WOT_OFS_DONE_CNT, c, "done_count");
  endtask
  task automatic hold_case(input logic [31:0] cfg, input logic act);
    rt_sel(2'h2);
    apb(1'b1, `WOT_OFS_HOLD, cfg);
    apb(1'b1, `WOT_OFS_DELAY, 32'h1);
    apb(1'b1, `WOT_OFS_DIVISOR, 32'h1);
    hold_lvl <= ~act;
    cmp_lvl <= ~act;
    apb(1'b1, `WOT_OFS_BEGIN, 32'h0);
    apb(1'b1, `WOT_OFS_CTRL, 32'h1);
    apb(1'b1, `WOT_OFS_CTRL, 32'h2);
    start_wait;
    hold_lvl <= act;
    cmp_lvl <= act;
    upd_q.delete();
    run <= 1'b1;
    cyc(40);
    run <= 1'b0;
    chk("held", 0, upd_q.size());
    chk("hold_export", 1, {31'h0, rt_out[0]});
    hold_lvl <= ~act;
    cmp_lvl <= ~act;
    cyc(6);
    chk("resume_onboard", 1, upd_q.size());
    chk("hold_export_off", 0, {31'h0, rt_out[0]});
    apb(1'b1, `WOT_OFS_CTRL, 32'h4);
    rt_sel(2'h0);
  endtask
  task automatic ext_case(input logic [31:0] cfg, input logic f);
    ext_lvl <= f;
    hold_lvl <= 1'b0;
    rt_sel(2'h1);
    apb(1'b1, `WOT_OFS_CLOCK, cfg);
    apb(1'b1, `WOT_OFS_HOLD, 32'h41);
    apb(1'b1, `WOT_OFS_CTRL, 32'h1);
    apb(1'b1, `WOT_OFS_CTRL, 32'h2);
    start_wait;
    upd_q.delete();
    pulse;
    chk("ext_update", 1, upd_q.size());
    hold_lvl <= 1'b1;
    pulse;
    chk("ext_held", 1, upd_q.size());
    hold_lvl <= 1'b0;
    cyc(8);
    chk("ext_no_resume", 1, upd_q.size());
    pulse;
    chk("ext_resume", 2, upd_q.size());
    apb(1'b1, `WOT_OFS_CTRL, 32'h4);
    rt_sel(2'h0);
  endtask
  // per-cycle monitor: ticks, pulses and exported lines
  always @(posedge pclk) if (presetn) begin
    if (tb100 && !tb_q) n_tick++;
    tb_q = tb100;
    if (beg === 1'b1) n_beg++;
    if (upd === 1'b1) begin
      upd_q.push_back(n_tick);
      n_all++;
    end
    chk("fifo_pop", {31'h0, upd}, {31'h0, pop});
    if (pfi_oe_n[5] === 1'b0) chk("update_export", {31'h0, ~upd}, {31'h0, pfi_out[5]});
    if (rt_oe_n[0] === 1'b0 && rt_mode == 2'h0)
      chk("begin_export", {31'h0, beg}, {31'h0, rt_out[0]});
    if (rt_oe_n[0] === 1'b0 && rt_mode == 2'h1)
      chk("rt_update_export", {31'h0, ~upd}, {31'h0, rt_out[0]});
  end
  initial begin
    cyc(30000);
    n_errors++;
    end_of_test;
  end
  initial begin
    {psel, penable, pwrite, run, begin_lvl, hold_lvl, ext_lvl, cmp_lvl, tb_q} = '0;
    paddr = 12'h000;
    rt_mode = 2'h0;
    pwdata = 32'h0;
    presetn = 1'b0;
    q = $urandom(32'h020B);
    cyc(5);
    presetn <= 1'b1;
    rd(`WOT_OFS_DELAY, 32'h2, "delay_reset");
    rd(`WOT_OFS_DIVISOR, 32'h2, "divisor_reset");
    rd(`WOT_OFS_STATUS, 32'h0, "status_reset");
    chk("pfi_oe_reset", 32'hFFFF, {16'h0, pfi_oe_n});
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, e});
    apb(1'b1, `WOT_OFS_EXPORT, 32'h00030020);
    // enables register on the landing edge, so look one edge later
    cyc(1);
    chk("pfi_drive", 32'hFFDF, {16'h0, pfi_oe_n});
    chk("rtsi_drive", 32'hFE, {24'h0, rt_oe_n});
    gen(5'h00, 1'b0, 2, 2, 3);
    for (int i = 0; i < 4; i++) gen(5'h00, i % 2 == 1, 1 + $urandom % 4, 1 + $urandom % 4,
                                    1 + $urandom % 4);
    gen(`WOT_SRC_CMP, 1'b1, 1, 1, 2);
    hold_case(32'h41, 1'b1);
    hold_case(32'h61, 1'b0);
    hold_case(32'h7B, 1'b1);
    ext_case(32'h0A, 1'b0);
    ext_case(32'h8A, 1'b1);
    ext_case(32'h01, 1'b0);
    end_of_test;
  end
endmodule

//--- verification/wot_src_model.sv
// ****************************************************************
// trigger, clock and sample fifo sources
// ****************************************************************
module wot_src_model #(
  parameter int HALF = 4
) (
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   run,
  input  wire logic   begin_lvl,
  input  wire logic   hold_lvl,
  input  wire logic   ext_lvl,
  input  wire logic   cmp_lvl,
  input  wire logic   fifo_pop,
  output logic [15:0] pfi,
  output logic [7:0]  rtsi,
  output logic [4:0]  misc,
  output logic        cmp,
  output logic        gp,
  output logic        tb100,
  output int          n_pop
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] noise;
  int         ph;
  // unused lines follow a free-running counter so a stale level never looks like a trigger
  assign pfi  = {noise, ~noise[4:0], ext_lvl, hold_lvl, begin_lvl};
  assign rtsi = ~noise;
  assign misc = noise[4:0];
  assign cmp  = cmp_lvl;
  assign gp   = ext_lvl;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      noise <= 8'h00;
      ph <= 0;
      tb100 <= 1'b0;
      n_pop <= 0;
    end else begin
      noise <= noise + 8'h01;
      n_pop <= n_pop + (fifo_pop ? 1 : 0);
      // timebase stands still when stopped, so tick counts stay exact
      if (run) begin
        ph <= (ph == HALF - 1) ? 0 : ph + 1;
        if (ph == HALF - 1) tb100 <= ~tb100;
      end
    end
  end
endmodule

//--- verilog/wot_pkg.sv
package wot_pkg;
  typedef enum logic [1:0] {
    WOT_IDLE  = 2'b00,
    WOT_ARMED = 2'b01,
    WOT_DELAY = 2'b11,
    WOT_RUN   = 2'b10
  } wot_state_e;
  typedef enum logic [1:0] {
    WOT_CLK_DIV  = 2'b00,
    WOT_CLK_GP   = 2'b01,
    WOT_CLK_EXT  = 2'b10,
    WOT_CLK_RSVD = 2'b11
  } wot_clk_mode_e;
  typedef enum logic [1:0] {
    WOT_RSEL_BEGIN  = 2'b00,
    WOT_RSEL_UPDATE = 2'b01,
    WOT_RSEL_HOLD   = 2'b10,
    WOT_RSEL_NONE   = 2'b11
  } wot_rsel_e;
  typedef logic [23:0] wot_cnt_t;
endpackage

//--- verilog/wot_regs.svh
`ifndef WOT_REGS_SVH
`define WOT_REGS_SVH
// ****************************************************************
// register offsets
// ****************************************************************
`define WOT_ADDR_W       12
`define WOT_OFS_CTRL     12'h000
`define WOT_OFS_BEGIN    12'h004
`define WOT_OFS_HOLD     12'h008
`define WOT_OFS_CLOCK    12'h00C
`define WOT_OFS_DIVISOR  12'h010
`define WOT_OFS_DELAY    12'h014
`define WOT_OFS_COUNT    12'h018
`define WOT_OFS_EXPORT   12'h01C
`define WOT_OFS_STATUS   12'h020
`define WOT_OFS_DONE_CNT 12'h024
// ****************************************************************
// field positions
// ****************************************************************
`define WOT_CTRL_ARM     0
`define WOT_CTRL_START   1
`define WOT_CTRL_STOP    2
`define WOT_CTRL_FINITE  3
`define WOT_CTRL_AUTO    4
`define WOT_SRC_LSB      0
`define WOT_SRC_MSB      4
`define WOT_EDGE_FALL    5
`define WOT_TRIG_EN      6
`define WOT_CLK_MODE_LSB 0
`define WOT_CLK_MODE_MSB 1
`define WOT_CLK_SRC_LSB  2
`define WOT_CLK_SRC_MSB  6
`define WOT_CLK_FALL     7
`define WOT_TB_SRC_LSB   8
`define WOT_TB_SRC_MSB   12
`define WOT_EXP_PFI_CLK  16
`define WOT_EXP_RTSI_LSB 17
`define WOT_EXP_RTSI_MSB 24
`define WOT_EXP_RSEL_LSB 25
`define WOT_EXP_RSEL_MSB 26
// ****************************************************************
// source indices and reset values
// ****************************************************************
`define WOT_SRC_STAR     5'h18
`define WOT_SRC_AIREF    5'h19
`define WOT_SRC_AIBEG    5'h1A
`define WOT_SRC_CMP      5'h1B
`define WOT_SRC_GPCNT    5'h1C
`define WOT_SRC_TB20M    5'h1D
`define WOT_SRC_TB100K   5'h1E
`define WOT_SRC_CLK10    5'h1F
`define WOT_DELAY_RST    24'h000002
`define WOT_DIVISOR_RST  24'h000002
`endif

//--- verilog/wot_timing.sv
`include "wot_regs.svh"
// Overview of operation
// - generation begins on selected start trigger, or software command alone
// - digital start trigger acts on configured rising or falling edge
// - comparator start trigger acts on its first rising edge
// - exported start trigger is an active-high pulse; terminals default input
// - active hold trigger masks all sample updates
// - hold never aborts a sample under way; acts from next sample
// - onboard divided clock resumes immediately when hold releases
// - other clock sources resume only on a further clock edge
// - digital hold trigger active level is configurable high or low
// - comparator hold trigger pauses while comparison event is high
// - each accepted sample updates every converter channel together
// - update launched on configured rising or falling update clock edge
// - update clock from timebase divider, counter output, or external source
// - exported update clock is driven active low
// - start trigger starts divider; stopped by hardware or software
// - configurable delay before first internal sample, default two ticks
// - timebase selectable from 20 MHz, 100 kHz, 10 MHz, terminals, comparator
// - timebase never exported to any connector terminal
// - hold trigger exported only on interboard trigger lines
// - each sample event fetches next FIFO word into converters
// - finite mode stops generation after programmed sample count
module wot_timing
  import wot_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`WOT_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [15:0]            programmable_function_terminals_in,
  input  wire logic [7:0]             interboard_trigger_lines_in,
  input  wire logic                   backplane_star_trigger,
  input  wire logic                   backplane_10mhz_clock,
  input  wire logic                   input_reference_trigger,
  input  wire logic                   input_begin_trigger,
  input  wire logic                   comparison_event,
  input  wire logic                   gp_counter_out,
  input  wire logic                   timebase_20mhz,
  input  wire logic                   timebase_100khz,
  output logic [15:0]                 programmable_function_terminals_out,
  output logic [15:0]                 programmable_function_terminals_oe_n,
  output logic [7:0]                  interboard_trigger_lines_out,
  output logic [7:0]                  interboard_trigger_lines_oe_n,
  output logic                        output_begin_trigger,
  output logic                        dac_update,
  output logic                        fifo_pop
);
  import wot_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    wot_state_e  st;
    logic [4:0]  ctrl;
    logic [6:0]  begin_cfg;
    logic [6:0]  hold_cfg;
    logic [12:0] clk_cfg;
    wot_cnt_t    divisor;
    wot_cnt_t    delay;
    wot_cnt_t    count;
    logic [26:0] exp_cfg;
    wot_cnt_t    cnt;
    wot_cnt_t    remain;
    wot_cnt_t    done_cnt;
    logic        pending;
    logic        prev_begin;
    logic        prev_clk;
    logic        prev_tb;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        begin_pulse;
    logic        update;
    logic [15:0] pfi_out;
    logic [15:0] pfi_oe_n;
    logic [7:0]  rtsi_out;
    logic [7:0]  rtsi_oe_n;
  } wot_state_s;

  wot_state_s s_ff;
  wot_state_s nxt_s;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic edge_hit(input logic cur, input logic prev, input logic fall);
    return fall ? (prev & ~cur) : (cur & ~prev);
  endfunction

  function automatic logic reg_hit(input logic [`WOT_ADDR_W-1:0] a);
    return (a <= `WOT_OFS_DONE_CNT) && (a[1:0] == 2'b00);
  endfunction

  logic [31:0]   src;
  logic          apb_wr;
  logic          sw_start;
  logic          cur_begin;
  logic          begin_edge;
  logic          begin_ev;
  logic          hold_act;
  logic          cur_tb;
  logic          tb_tick;
  logic          cur_clk;
  logic          upd_edge;
  logic          div_mode;
  logic          raw;
  logic          fin_block;
  logic          fire;
  wot_clk_mode_e cmode;
  wot_rsel_e     rsel;

  // comparator sits on its own index so both triggers can use it
  assign src = {backplane_10mhz_clock, timebase_100khz, timebase_20mhz, gp_counter_out,
                comparison_event, input_begin_trigger, input_reference_trigger,
                backplane_star_trigger, interboard_trigger_lines_in,
                programmable_function_terminals_in};

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    nxt_s = s_ff;
    nxt_s.begin_pulse = 1'b0;
    nxt_s.update = 1'b0;
    apb_wr = psel & penable & s_ff.pready & pwrite;
    sw_start = apb_wr && (paddr == `WOT_OFS_CTRL) && pwdata[`WOT_CTRL_START];
    cmode = wot_clk_mode_e'(s_ff.clk_cfg[`WOT_CLK_MODE_MSB:`WOT_CLK_MODE_LSB]);
    rsel = wot_rsel_e'(s_ff.exp_cfg[`WOT_EXP_RSEL_MSB:`WOT_EXP_RSEL_LSB]);
    div_mode = (cmode == WOT_CLK_DIV);

    cur_begin = src[s_ff.begin_cfg[`WOT_SRC_MSB:`WOT_SRC_LSB]];
    nxt_s.prev_begin = cur_begin;
    if (s_ff.begin_cfg[`WOT_SRC_MSB:`WOT_SRC_LSB] == `WOT_SRC_CMP) begin
      begin_edge = edge_hit(cur_begin, s_ff.prev_begin, 1'b0);
    end else begin
      begin_edge = edge_hit(cur_begin, s_ff.prev_begin, s_ff.begin_cfg[`WOT_EDGE_FALL]);
    end
    begin_ev = sw_start | (s_ff.begin_cfg[`WOT_TRIG_EN] & begin_edge);

    if (s_ff.hold_cfg[`WOT_SRC_MSB:`WOT_SRC_LSB] == `WOT_SRC_CMP) begin
      hold_act = s_ff.hold_cfg[`WOT_TRIG_EN] & comparison_event;
    end else begin
      hold_act = s_ff.hold_cfg[`WOT_TRIG_EN]
               & (src[s_ff.hold_cfg[`WOT_SRC_MSB:`WOT_SRC_LSB]]
                  ^ s_ff.hold_cfg[`WOT_EDGE_FALL]);
    end

    // timebase select; sampled at pclk, so fast timebases alias
    cur_tb = src[s_ff.clk_cfg[`WOT_TB_SRC_MSB:`WOT_TB_SRC_LSB]];
    nxt_s.prev_tb = cur_tb;
    tb_tick = edge_hit(cur_tb, s_ff.prev_tb, 1'b0);

    cur_clk = (cmode == WOT_CLK_GP) ? gp_counter_out
            : src[s_ff.clk_cfg[`WOT_CLK_SRC_MSB:`WOT_CLK_SRC_LSB]];
    nxt_s.prev_clk = cur_clk;
    upd_edge = edge_hit(cur_clk, s_ff.prev_clk, s_ff.clk_cfg[`WOT_CLK_FALL]);

    fin_block = s_ff.ctrl[`WOT_CTRL_FINITE] && (s_ff.remain == '0);
    raw = 1'b0;
    fire = 1'b0;

    unique case (s_ff.st)
      WOT_IDLE: begin
        if (apb_wr && (paddr == `WOT_OFS_CTRL) && pwdata[`WOT_CTRL_ARM]) begin
          nxt_s.st = WOT_ARMED;
          nxt_s.remain = s_ff.count;
          nxt_s.done_cnt = '0;
          nxt_s.pending = 1'b0;
        end
      end
      WOT_ARMED: begin
        if (begin_ev) begin
          nxt_s.begin_pulse = 1'b1;
          if (div_mode) begin
            nxt_s.st = WOT_DELAY;
            nxt_s.cnt = s_ff.delay;
          end else begin
            nxt_s.st = WOT_RUN;
          end
        end
      end
      WOT_DELAY: begin
        if (tb_tick) begin
          if (s_ff.cnt <= 24'h000001) begin
            raw = 1'b1;
            nxt_s.cnt = s_ff.divisor;
            nxt_s.st = WOT_RUN;
          end else begin
            nxt_s.cnt = s_ff.cnt - 24'h000001;
          end
        end
      end
      WOT_RUN: begin
        if (div_mode) begin
          if (tb_tick) begin
            if (s_ff.cnt <= 24'h000001) begin
              raw = 1'b1;
              nxt_s.cnt = s_ff.divisor;
            end else begin
              nxt_s.cnt = s_ff.cnt - 24'h000001;
            end
          end
        end else begin
          raw = upd_edge;
        end
      end
    endcase

    if ((s_ff.st == WOT_DELAY) || (s_ff.st == WOT_RUN)) begin
      // hold masks; checked only when a sample starts
      if (raw && !hold_act && !fin_block) begin
        fire = 1'b1;
        nxt_s.pending = 1'b0;
      end else if (raw && div_mode) begin
        nxt_s.pending = 1'b1;
      end else if (s_ff.pending && div_mode && !hold_act && !fin_block) begin
        fire = 1'b1;
        nxt_s.pending = 1'b0;
      end
      // other sources simply wait for next edge
      if (!div_mode) begin
        nxt_s.pending = 1'b0;
      end
    end

    if (fire) begin
      nxt_s.update = 1'b1;
      nxt_s.done_cnt = s_ff.done_cnt + 24'h000001;
      if (s_ff.ctrl[`WOT_CTRL_FINITE]) begin
        nxt_s.remain = s_ff.remain - 24'h000001;
        if ((s_ff.remain == 24'h000001) && s_ff.ctrl[`WOT_CTRL_AUTO]) begin
          nxt_s.st = WOT_IDLE;
        end
      end
    end

    // ****************************************************************
    // apb slave: one wait state, data prepared in setup cycle
    // ****************************************************************
    nxt_s.pready = psel & ~penable;
    if (psel && !penable) begin
      nxt_s.pslverr = !reg_hit(paddr);
      unique case (paddr)
        `WOT_OFS_CTRL:     nxt_s.prdata = {27'h0, s_ff.ctrl};
        `WOT_OFS_BEGIN:    nxt_s.prdata = {25'h0, s_ff.begin_cfg};
        `WOT_OFS_HOLD:     nxt_s.prdata = {25'h0, s_ff.hold_cfg};
        `WOT_OFS_CLOCK:    nxt_s.prdata = {19'h0, s_ff.clk_cfg};
        `WOT_OFS_DIVISOR:  nxt_s.prdata = {8'h0, s_ff.divisor};
        `WOT_OFS_DELAY:    nxt_s.prdata = {8'h0, s_ff.delay};
        `WOT_OFS_COUNT:    nxt_s.prdata = {8'h0, s_ff.count};
        `WOT_OFS_EXPORT:   nxt_s.prdata = {5'h0, s_ff.exp_cfg};
        `WOT_OFS_STATUS:   nxt_s.prdata = {27'h0, fin_block, hold_act, s_ff.pending,
                                           s_ff.st};
        `WOT_OFS_DONE_CNT: nxt_s.prdata = {8'h0, s_ff.done_cnt};
        default:           nxt_s.prdata = 32'h0000_0000;
      endcase
    end
    if (apb_wr) begin
      unique case (paddr)
        `WOT_OFS_CTRL: begin
          nxt_s.ctrl = {pwdata[`WOT_CTRL_AUTO:`WOT_CTRL_FINITE], 3'h0};
          if (pwdata[`WOT_CTRL_STOP]) begin
            nxt_s.st = WOT_IDLE;
          end
        end
        `WOT_OFS_BEGIN:   nxt_s.begin_cfg = pwdata[6:0];
        `WOT_OFS_HOLD:    nxt_s.hold_cfg = pwdata[6:0];
        `WOT_OFS_CLOCK:   nxt_s.clk_cfg = pwdata[12:0];
        `WOT_OFS_DIVISOR: nxt_s.divisor = pwdata[23:0];
        `WOT_OFS_DELAY:   nxt_s.delay = pwdata[23:0];
        `WOT_OFS_COUNT:   nxt_s.count = pwdata[23:0];
        `WOT_OFS_EXPORT:  nxt_s.exp_cfg = pwdata[26:0];
        default: begin
        end
      endcase
    end

    // ****************************************************************
    // terminal export; timebase has no path out
    // ****************************************************************
    // timebase absent, high pulse, active-low clock
    nxt_s.pfi_oe_n = ~nxt_s.exp_cfg[15:0];
    nxt_s.pfi_out = nxt_s.exp_cfg[`WOT_EXP_PFI_CLK] ? {16{~nxt_s.update}}
                  : {16{nxt_s.begin_pulse}};
    nxt_s.pfi_out = nxt_s.pfi_out & nxt_s.exp_cfg[15:0];
    nxt_s.rtsi_oe_n = ~nxt_s.exp_cfg[`WOT_EXP_RTSI_MSB:`WOT_EXP_RTSI_LSB];
    unique case (wot_rsel_e'(nxt_s.exp_cfg[`WOT_EXP_RSEL_MSB:`WOT_EXP_RSEL_LSB]))
      WOT_RSEL_BEGIN:  nxt_s.rtsi_out = {8{nxt_s.begin_pulse}};
      WOT_RSEL_UPDATE: nxt_s.rtsi_out = {8{~nxt_s.update}};
      WOT_RSEL_HOLD:   nxt_s.rtsi_out = {8{hold_act}};
      WOT_RSEL_NONE:   nxt_s.rtsi_out = 8'h00;
    endcase
    nxt_s.rtsi_out = nxt_s.rtsi_out & nxt_s.exp_cfg[`WOT_EXP_RTSI_MSB:`WOT_EXP_RTSI_LSB];
    if (rsel == WOT_RSEL_NONE) begin
      nxt_s.rtsi_oe_n = nxt_s.rtsi_oe_n;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
      s_ff.delay <= `WOT_DELAY_RST;
      s_ff.divisor <= `WOT_DIVISOR_RST;
      s_ff.pfi_oe_n <= 16'hFFFF;
      s_ff.rtsi_oe_n <= 8'hFF;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = s_ff.pslverr;
  assign programmable_function_terminals_out = s_ff.pfi_out;
  assign programmable_function_terminals_oe_n = s_ff.pfi_oe_n;
  assign interboard_trigger_lines_out = s_ff.rtsi_out;
  assign interboard_trigger_lines_oe_n = s_ff.rtsi_oe_n;
  assign output_begin_trigger = s_ff.begin_pulse;
  assign dac_update = s_ff.update;
  assign fifo_pop = s_ff.update;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_SW_START_BEGINS: assert property (
    (s_ff.st == WOT_ARMED) && sw_start |=> s_ff.begin_pulse ##1 !s_ff.begin_pulse
  ) else $error("software start did not give one begin pulse");
  AST_ARMED_QUIET: assert property (
    (s_ff.st == WOT_ARMED) |=> !s_ff.update
  ) else $error("update while armed");
  AST_HOLD_MASKS: assert property (
    hold_act |=> !s_ff.update
  ) else $error("update while hold active");
  AST_EXT_NEEDS_EDGE: assert property (
    !div_mode && !upd_edge |=> !s_ff.update
  ) else $error("external update without edge");
  AST_ONBOARD_RESUME: assert property (
    (s_ff.st == WOT_RUN) && div_mode && s_ff.pending && !hold_act && !fin_block
    |=> s_ff.update && !s_ff.pending
  ) else $error("onboard clock did not resume");
  AST_DELAY_FIRST: assert property (
    (s_ff.st == WOT_DELAY) && tb_tick && (s_ff.cnt == 24'h000001) && !hold_act && !fin_block
    |=> s_ff.update && (s_ff.st != WOT_DELAY)
  ) else $error("first sample not after delay");
  AST_DIV_RELOAD: assert property (
    (s_ff.st == WOT_RUN) && div_mode && tb_tick && (s_ff.cnt == 24'h000001) && !apb_wr
    |=> s_ff.cnt == $past(s_ff.divisor)
  ) else $error("divider did not reload");
  AST_FINITE_STOP: assert property (
    fin_block && !apb_wr |=> !s_ff.update
  ) else $error("update beyond finite count");
  AST_CLK_EXPORT_LOW: assert property (
    s_ff.update && s_ff.exp_cfg[`WOT_EXP_PFI_CLK]
    |-> ((s_ff.pfi_out | s_ff.pfi_oe_n) & s_ff.exp_cfg[15:0]) == 16'h0000
  ) else $error("exported update clock not active low");
  AST_APB_ANSWER: assert property (
    psel && !penable |=> s_ff.pready ##1 !s_ff.pready
  ) else $error("apb answer not one wait state");

  COV_FINITE_DONE: cover property ((s_ff.st == WOT_RUN) ##1 (s_ff.st == WOT_IDLE));
  COV_PAUSE_RESUME: cover property (s_ff.pending ##1 s_ff.update);
  COV_EXT_UPDATE: cover property (!div_mode && s_ff.update);
endmodule
